// file: pgf_pkg.sv
// constants shared by the power-ok and event-flag block
package pgf_pkg;
    // ------------------------------------------------------------------
    // bus and timing
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned GATE_TIME_US = 800;
    localparam int unsigned GATE_CYC     = GATE_TIME_US * CLK_MHZ;
    localparam int unsigned NRAIL        = 4;
    localparam int unsigned NFLAG        = 8;
    localparam int unsigned NMASK        = 6;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CTRL1  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CTRL2  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_FAULT  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_RESET  = 8'h18;

    // ------------------------------------------------------------------
    // flag, mask and status bit positions
    // ------------------------------------------------------------------
    localparam int unsigned F_LDO  = 0;
    localparam int unsigned F_POK  = 2;
    localparam int unsigned F_SYNC = 3;
    localparam int unsigned F_MEAS = 4;
    localparam int unsigned F_RST  = 5;
    localparam int unsigned F_OVP  = 6;
    localparam int unsigned F_TSD  = 7;
    localparam int unsigned S_LDO  = 0;
    localparam int unsigned S_POK  = 2;
    localparam int unsigned S_SYNC = 3;
    localparam int unsigned S_TW   = 4;
    localparam int unsigned S_OVP  = 5;
    localparam int unsigned S_TSD  = 6;

    // ------------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned C1_WIN  = 4;
    localparam int unsigned C1_POL  = 8;
    localparam int unsigned C1_OD   = 9;
    localparam int unsigned C2_TW   = 0;
    localparam int unsigned C2_MODE = 1;
    localparam int unsigned C2_HOLD = 2;
    localparam int unsigned R_SWRST = 0;
    localparam logic [9:0]       CTRL1_RST = 10'h00F;
    localparam logic [2:0]       CTRL2_RST = 3'h0;
    localparam logic [NMASK-1:0] MASK_RST  = 6'h00;
endpackage

// file: pgf_w1c_flags.sv
// sticky flags: hardware set wins over write-one clear
`timescale 1ns/100ps
module pgf_w1c_flags #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    // control
    input  wire logic         init,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else if (init) begin
            q <= set;
        end else begin
            q <= (q & ~clr) | set;
        end
    end
endmodule // pgf_w1c_flags

// file: pgf_gate_timer.sv
// gated-period timer: restarts on request, done when run out
`timescale 1ns/100ps
module pgf_gate_timer #(
    parameter int unsigned CYCLES = 200000
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // control
    input  wire logic clear,
    input  wire logic restart,
    output logic      done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (restart) begin
            cnt_q <= CW'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done = (cnt_q == '0);
endmodule // pgf_gate_timer

// file: pgf_power_ok.sv
// power-ok aggregation, fault latches and event flags behind apb
// Contract
// - ldo leaving valid range sets its flag
// - power-ok falling edge sets power-ok flag
// - external clock change sets sync flag
// - measurement done sets measurement flag
// - supply recovery resets registers, sets reset flag
// - software reset restores defaults, sets reset flag
// - polarity inverts pin only, not status
// - sync flag also while detector on, clock absent
// - per-rail select of voltage monitor
// - disabled rail never forces power-ok low
// - optional thermal warning source
// - power-ok needs every selected source valid
// - window bit adds overvoltage check
// - pin polarity and open-drain selectable
// - mode bit picks gated or continuous
// - gated mode holds output during period
// - gated fault latches and stops monitoring
// - continuous starts active, drops on enable
// - continuous fault bits latch until cleared
// - ramping rail forces power-ok inactive in continuous mode
// - continuous mode follows validity again
// - fault-hold bit keeps power-ok inactive
// - interrupt low while any flag pending
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module pgf_power_ok
    import pgf_pkg::*;
#(
    parameter int unsigned GATE_CYCLES = pgf_pkg::GATE_CYC
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [pgf_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [pgf_pkg::DATA_W-1:0]  pwdata,
    output logic      [pgf_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // rail monitors, rails 0-1 switchers, 2-3 linear
    input  wire logic [pgf_pkg::NRAIL-1:0]   rail_en,
    input  wire logic [pgf_pkg::NRAIL-1:0]   rail_uv_ok,
    input  wire logic [pgf_pkg::NRAIL-1:0]   rail_ov_ok,
    input  wire logic [pgf_pkg::NRAIL-1:0]   rail_ramp,
    input  wire logic                        volt_change_req,
    // other event sources
    input  wire logic                        thermal_warn_status,
    input  wire logic                        ovp_det,
    input  wire logic                        tsd_det,
    input  wire logic                        ext_clk_present,
    input  wire logic                        clk_det_en,
    input  wire logic                        meas_done,
    // one-time-programmed defaults
    input  wire logic                        otp_mode,
    input  wire logic                        otp_reset_mask,
    // pins
    output logic                             power_ok_pin_out,
    output logic                             power_ok_pin_oe,
    output logic                             irq_out_n,
    output logic                             sw_shutdown
);
    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    logic                pready_q;
    logic                acc;
    logic [9:0]          ctrl1_q;
    logic [2:0]          ctrl2_q;
    logic [NMASK-1:0]    mask_q;
    logic [NFLAG-1:0]    flag_q;
    logic [NFLAG-1:0]    flag_set;
    logic [NFLAG-1:0]    flag_clr;
    logic [NRAIL-1:0]    fault_q;
    logic [NRAIL-1:0]    fault_clr;
    logic [6:0]          status;
    logic [DATA_W-1:0]   rd_data;
    logic                rd_err;
    logic                boot_q;
    logic                sw_rst_q;
    logic                load;

    function automatic logic wr_at(input logic [ADDR_W-1:0] off);
        return acc && pwrite && (paddr == off);
    endfunction

    assign acc = psel & penable & pready_q;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
            prdata   <= '0;
            pslverr  <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr  <= psel & penable & ~pready_q & rd_err;
            if (psel && penable && !pready_q && !pwrite) begin
                prdata <= rd_data;
            end
        end
    end
    assign pready = pready_q;

    always_comb begin
        rd_err = 1'b0;
        case (paddr)
            OFF_FLAGS:  rd_data = DATA_W'(flag_q);
            OFF_MASK:   rd_data = DATA_W'(mask_q);
            OFF_STATUS: rd_data = DATA_W'(status);
            OFF_CTRL1:  rd_data = DATA_W'(ctrl1_q);
            OFF_CTRL2:  rd_data = DATA_W'(ctrl2_q);
            OFF_FAULT:  rd_data = DATA_W'(fault_q);
            OFF_RESET:  rd_data = '0;
            default: begin
                rd_data = '0;
                rd_err  = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // reset sequencing
    // ------------------------------------------------------------------
    // boot after supply
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_q <= 1'b0;
        end else begin
            boot_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_rst_q <= 1'b0;
        end else begin
            sw_rst_q <= wr_at(OFF_RESET) & pwdata[R_SWRST];
        end
    end
    assign sw_shutdown = sw_rst_q;
    assign load        = ~boot_q | sw_rst_q;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // rail select, window, pin type
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_q <= CTRL1_RST;
        end else if (sw_rst_q) begin
            ctrl1_q <= CTRL1_RST;
        end else if (wr_at(OFF_CTRL1)) begin
            ctrl1_q <= pwdata[9:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl2_q <= CTRL2_RST;
        end else if (load) begin
            ctrl2_q          <= CTRL2_RST;
            ctrl2_q[C2_MODE] <= otp_mode;
        end else if (wr_at(OFF_CTRL2)) begin
            ctrl2_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= MASK_RST;
        end else if (load) begin
            mask_q        <= MASK_RST;
            mask_q[F_RST] <= otp_reset_mask;
        end else if (wr_at(OFF_MASK)) begin
            mask_q <= pwdata[NMASK-1:0];
        end
    end

    // ------------------------------------------------------------------
    // rail monitoring
    // ------------------------------------------------------------------
    logic [NRAIL-1:0] mon;
    logic [NRAIL-1:0] valid;
    logic [NRAIL-1:0] bad;
    logic [NRAIL-1:0] en_prev_q;
    logic             ramp_mon;
    logic             tw_bad;
    logic             tmr_done;
    logic             armed_q;
    logic             gated;
    logic             fault_evt;
    logic             common_ok;
    logic             pok_q;
    logic             pok_d;
    logic             tmr_restart;
    logic             tmr_open;

    assign mon      = ctrl1_q[NRAIL-1:0] & rail_en;
    assign valid    = rail_uv_ok & (~ctrl1_q[C1_WIN +: NRAIL] | rail_ov_ok);
    assign bad      = mon & ~valid;
    assign ramp_mon = |(mon & rail_ramp);
    assign tw_bad   = ctrl2_q[C2_TW] & thermal_warn_status;
    assign gated    = ~ctrl2_q[C2_MODE];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_prev_q <= '0;
        end else begin
            en_prev_q <= rail_en;
        end
    end

    // restart on enable or voltage change
    assign tmr_restart = |(rail_en & ~en_prev_q) | volt_change_req;
    // the request cycle itself already counts as gated
    assign tmr_open    = tmr_done & ~tmr_restart;

    pgf_gate_timer #(
        .CYCLES (GATE_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clear   (sw_rst_q),
        .restart (tmr_restart),
        .done    (tmr_done)
    );

    // armed once any regulator is enabled
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_q <= 1'b0;
        end else if (sw_rst_q) begin
            armed_q <= 1'b0;
        end else if (|rail_en) begin
            armed_q <= 1'b1;
        end
    end

    assign fault_evt = gated ? tmr_open : (armed_q & ~ramp_mon);
    assign fault_clr = wr_at(OFF_FAULT) ? pwdata[NRAIL-1:0] : '0;

    pgf_w1c_flags #(
        .W (NRAIL)
    ) u_fault (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .init    (sw_rst_q),
        .set     (bad & {NRAIL{fault_evt}}),
        .clr     (fault_clr),
        .q       (fault_q)
    );

    // thermal, overvoltage and shutdown sources valid, optional fault hold
    assign common_ok = ~tw_bad & ~flag_q[F_OVP] & ~flag_q[F_TSD]
                     & ~(ctrl2_q[C2_HOLD] & |fault_q);

    always_comb begin
        if (gated) begin
            // frozen in period, then faults gate
            pok_d = tmr_open ? (~|(bad | fault_q) & common_ok) : pok_q;
        end else begin
            pok_d = ~armed_q | (~|bad & ~ramp_mon & common_ok);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pok_q <= 1'b1;
        end else if (sw_rst_q) begin
            pok_q <= 1'b1;
        end else begin
            pok_q <= pok_d;
        end
    end

    // polarity and drive type on the pin only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_ok_pin_out <= 1'b1;
            power_ok_pin_oe  <= 1'b1;
        end else if (ctrl1_q[C1_OD]) begin
            power_ok_pin_out <= 1'b0;
            power_ok_pin_oe  <= ~(pok_q ^ ctrl1_q[C1_POL]);
        end else begin
            power_ok_pin_out <= pok_q ^ ctrl1_q[C1_POL];
            power_ok_pin_oe  <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------------
    logic [1:0] ldo_ok;
    logic [1:0] ldo_prev_q;
    logic       clk_prev_q;

    assign ldo_ok = valid[3:2] & rail_en[3:2];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ldo_prev_q <= '0;
            clk_prev_q <= 1'b0;
        end else begin
            ldo_prev_q <= ldo_ok;
            clk_prev_q <= ext_clk_present;
        end
    end

    always_comb begin
        flag_set[F_LDO +: 2] = ldo_prev_q & ~ldo_ok & ~mask_q[F_LDO +: 2];
        flag_set[F_POK]  = pok_q & ~pok_d & ~mask_q[F_POK];
        flag_set[F_SYNC] = clk_det_en & ~mask_q[F_SYNC]
                         & ((clk_prev_q ^ ext_clk_present) | ~ext_clk_present);
        flag_set[F_MEAS] = meas_done & ~mask_q[F_MEAS];
        flag_set[F_RST]  = load & ~otp_reset_mask;
        flag_set[F_OVP]  = ovp_det;
        flag_set[F_TSD]  = tsd_det;
    end

    assign flag_clr = wr_at(OFF_FLAGS) ? pwdata[NFLAG-1:0] : '0;

    pgf_w1c_flags #(
        .W (NFLAG)
    ) u_flags (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .init    (sw_rst_q),
        .set     (flag_set),
        .clr     (flag_clr),
        .q       (flag_q)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~|flag_q;
        end
    end

    // status reads internal power-ok, not pin
    always_comb begin
        status            = '0;
        status[S_LDO +: 2] = ldo_ok;
        status[S_POK]     = pok_q;
        status[S_SYNC]    = ext_clk_present;
        status[S_TW]      = thermal_warn_status;
        status[S_OVP]     = ovp_det;
        status[S_TSD]     = tsd_det;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_swrst_write;
        acc && pwrite && paddr == OFF_RESET && pwdata[R_SWRST];
    endsequence

    sequence s_pok_fall;
        pok_q && !pok_d && !mask_q[F_POK] && !sw_rst_q;
    endsequence

    a_irq_pending: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (|flag_q) |=> !irq_out_n) else $error("irq not low with pending flag");
    a_pin_polarity: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !ctrl1_q[C1_OD] |=> power_ok_pin_out == ($past(pok_q) ^ $past(ctrl1_q[C1_POL])))
        else $error("pin level does not follow status and polarity");
    a_gate_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        gated && !tmr_open && !sw_rst_q |=> pok_q == $past(pok_q)) else $error("power ok moved in gated period");
    a_ramp_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !gated && armed_q && ramp_mon && !sw_rst_q |=> !pok_q) else $error("power ok active while ramping");
    a_fault_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !gated && armed_q && ctrl2_q[C2_HOLD] && (|fault_q) && !sw_rst_q |=> !pok_q)
        else $error("power ok active with fault held");
    a_tsd_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !gated && armed_q && flag_q[F_TSD] && !sw_rst_q |=> !pok_q) else $error("power ok active with shutdown flag");
    a_pok_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_pok_fall |=> flag_q[F_POK] ##1 !irq_out_n) else $error("power ok fall not flagged");
    a_meas_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        meas_done && !mask_q[F_MEAS] && !sw_rst_q |=> flag_q[F_MEAS]) else $error("measurement flag missed");
    a_swrst_seq: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_swrst_write ##1 (!otp_reset_mask) |=> flag_q[F_RST] && ctrl1_q == CTRL1_RST && pok_q)
        else $error("software reset did not restore and flag");
endmodule // pgf_power_ok

// file: pgf_host_model.sv
// host side model: resolves the power-ok pin and watches the interrupt line
`timescale 1ns/100ps
module pgf_host_model (
    // design pins
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic irq_out_n,
    // levels seen by the host
    output logic      pin_level,
    output logic      irq_active
);
    assign pin_level  = pin_oe ? pin_out : 1'b1;
    assign irq_active = ~irq_out_n;
endmodule // pgf_host_model

// file: pgf_power_ok_tb_top.sv
// self-checking bench for the power-ok and event-flag block
`timescale 1ns/100ps
module pgf_power_ok_tb_top;
    import pgf_pkg::*;
    localparam int unsigned GATE = 20;
    logic              sys_clk = 1'b0;
    logic              arst_n = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata;
    logic              pready, pslverr;
    logic [NRAIL-1:0]  rail_en = 4'h0, rail_uv_ok = 4'hF, rail_ov_ok = 4'hF, rail_ramp = 4'h0;
    logic              volt_change_req = 1'b0, thermal_warn_status = 1'b0, ovp_det = 1'b0;
    logic              tsd_det = 1'b0, ext_clk_present = 1'b0, clk_det_en = 1'b0, meas_done = 1'b0;
    logic              otp_mode = 1'b0, otp_reset_mask = 1'b0;
    logic              power_ok_pin_out, power_ok_pin_oe, irq_out_n, sw_shutdown;
    logic              pin_level, irq_active;
    int                failures = 0;
    int                n_checks = 0;
    int                n_sd = 0;
    logic [31:0]       rd_q;
    logic              err_q;

    always #2 sys_clk = ~sys_clk;

    // counts edges at which the shutdown pulse stands
    always @(posedge sys_clk) begin
        if (sw_shutdown === 1'b1) begin
            n_sd <= n_sd + 1;
        end
    end

    pgf_power_ok #(.GATE_CYCLES(GATE)) i_dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rail_en, .rail_uv_ok, .rail_ov_ok, .rail_ramp,
        .volt_change_req, .thermal_warn_status, .ovp_det, .tsd_det, .ext_clk_present, .clk_det_en,
        .meas_done, .otp_mode, .otp_reset_mask, .power_ok_pin_out, .power_ok_pin_oe, .irq_out_n,
        .sw_shutdown);

    pgf_host_model i_host (.pin_out(power_ok_pin_out), .pin_oe(power_ok_pin_oe), .irq_out_n(irq_out_n),
        .pin_level(pin_level), .irq_active(irq_active));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge, leaves one idle edge after the answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd_q & m, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic pin_is(input int n, input logic exp);
        wait_cyc(n);
        @(negedge sys_clk);
        chk({31'h0, pin_level}, {31'h0, exp});
        @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        pin_is(2, 1'b1);
        chk({31'h0, irq_active}, 32'h1);
        rd(OFF_FLAGS, 32'hFFFF_FFFF, 32'h0000_0020);
        rd(OFF_CTRL1, 32'hFFFF_FFFF, 32'h0000_000F);
        rd(OFF_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b1, OFF_FLAGS, 32'h0000_0020);
        pin_is(3, 1'b1);
        chk({31'h0, irq_active}, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk({rd_q[30:0], err_q}, 32'h1);
    endtask

    task automatic t_events;
        meas_done <= 1'b1;
        @(posedge sys_clk);
        meas_done <= 1'b0;
        rd(OFF_FLAGS, 32'h0000_0010, 32'h0000_0010);
        apb(1'b1, OFF_FLAGS, 32'h0000_00FF);
        apb(1'b1, OFF_MASK, 32'h0000_0010);
        meas_done <= 1'b1;
        @(posedge sys_clk);
        meas_done <= 1'b0;
        rd(OFF_FLAGS, 32'h0000_0010, 32'h0000_0000);
        clk_det_en <= 1'b1;
        rd(OFF_FLAGS, 32'h0000_0008, 32'h0000_0008);
        ext_clk_present <= 1'b1;
        apb(1'b1, OFF_FLAGS, 32'h0000_00FF);
        rd(OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
        ext_clk_present <= 1'b0;
        rd(OFF_FLAGS, 32'h0000_0008, 32'h0000_0008);
        clk_det_en <= 1'b0;
        ext_clk_present <= 1'b1;
        apb(1'b1, OFF_FLAGS, 32'h0000_00FF);
    endtask

    task automatic t_gated;
        rail_en <= 4'h1;
        wait_cyc(2);
        rail_uv_ok <= 4'hE;
        pin_is(6, 1'b1);
        pin_is(GATE + 8, 1'b0);
        rd(OFF_FLAGS, 32'h0000_0004, 32'h0000_0004);
        rd(OFF_FAULT, 32'hFFFF_FFFF, 32'h0000_0001);
        rail_uv_ok <= 4'hF;
        pin_is(GATE + 8, 1'b0);
        apb(1'b1, OFF_FAULT, 32'h0000_0001);
        pin_is(4, 1'b1);
        volt_change_req <= 1'b1;
        rail_uv_ok <= 4'hE;
        @(posedge sys_clk);
        volt_change_req <= 1'b0;
        pin_is(6, 1'b1);
        pin_is(GATE + 8, 1'b0);
        rail_uv_ok <= 4'hF;
        rail_en <= 4'h0;
        apb(1'b1, OFF_FAULT, 32'h0000_000F);
        apb(1'b1, OFF_FLAGS, 32'h0000_00FF);
    endtask

    task automatic t_swrst;
        int n0;
        n0 = n_sd;
        apb(1'b1, OFF_CTRL1, 32'h0000_0123);
        otp_mode <= 1'b1;
        apb(1'b1, OFF_RESET, 32'h0000_0001);
        wait_cyc(2);
        chk(n_sd - n0, 32'h1);
        rd(OFF_CTRL1, 32'hFFFF_FFFF, 32'h0000_000F);
        rd(OFF_FLAGS, 32'hFFFF_FFFF, 32'h0000_0020);
        rd(OFF_CTRL2, 32'hFFFF_FFFF, 32'h0000_0002);
        apb(1'b1, OFF_FLAGS, 32'h0000_00FF);
    endtask

    task automatic t_cont;
        apb(1'b1, OFF_CTRL2, 32'h0000_0002);
        rail_uv_ok <= 4'h3;
        pin_is(4, 1'b1);
        rail_en <= 4'h4;
        pin_is(4, 1'b0);
        rd(OFF_FLAGS, 32'h0000_0003, 32'h0000_0000);
        rail_uv_ok <= 4'h7;
        pin_is(4, 1'b1);
        rd(OFF_FAULT, 32'hFFFF_FFFF, 32'h0000_0004);
        apb(1'b1, OFF_CTRL2, 32'h0000_0006);
        pin_is(4, 1'b0);
        apb(1'b1, OFF_FAULT, 32'h0000_0004);
        pin_is(4, 1'b1);
        rail_ramp <= 4'h4;
        pin_is(4, 1'b0);
        rail_ramp <= 4'h0;
        rail_ov_ok <= 4'hB;
        pin_is(4, 1'b1);
        apb(1'b1, OFF_CTRL1, 32'h0000_004F);
        pin_is(4, 1'b0);
        rd(OFF_FLAGS, 32'h0000_0003, 32'h0000_0001);
        apb(1'b1, OFF_CTRL1, 32'h0000_000B);
        rail_uv_ok <= 4'hB;
        apb(1'b1, OFF_FAULT, 32'h0000_0004);
        pin_is(4, 1'b1);
        rail_ov_ok <= 4'hF;
        rail_uv_ok <= 4'hF;
        apb(1'b1, OFF_FAULT, 32'h0000_000F);
        apb(1'b1, OFF_CTRL1, 32'h0000_010F);
        pin_is(4, 1'b0);
        rd(OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
        apb(1'b1, OFF_CTRL1, 32'h0000_020F);
        pin_is(4, 1'b1);
        chk({31'h0, power_ok_pin_oe}, 32'h0);
        apb(1'b1, OFF_CTRL1, 32'h0000_000F);
        ovp_det <= 1'b1;
        pin_is(4, 1'b0);
        ovp_det <= 1'b0;
        apb(1'b1, OFF_FLAGS, 32'h0000_00FF);
        pin_is(4, 1'b1);
        thermal_warn_status <= 1'b1;
        pin_is(4, 1'b1);
        apb(1'b1, OFF_CTRL2, 32'h0000_0003);
        pin_is(4, 1'b0);
        thermal_warn_status <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        wait_cyc(16);
        arst_n <= 1'b1;
        wait_cyc(2);
        t_reset();
        t_events();
        t_gated();
        t_swrst();
        t_cont();
        print_verdict();
    end

    initial begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule // pgf_power_ok_tb_top
